// [rtv_value_regs.sv]
// Clock/calendar value registers behind pointer-selected windows
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps

module rtv_value_regs
#(
   parameter logic [31:0] TICK_DIV = rtv_pkg::RTV_TICKDIV_RST
)
(
   input  wire logic              clk,
   input  wire logic              rst_b,
   input  wire rtv_pkg::rtv_req_s busReq,
   output logic [31:0]            rdData
);
   import rtv_pkg::*;

   // ----------------------------------------------------------------
   // Control and storage
   // ----------------------------------------------------------------
   logic [15:0] ctrl_reg;
   logic [31:0] tickDiv_reg;
   logic [31:0] tickCnt_reg;
   rtv_wdhr_s   timeWdHr_reg;
   rtv_minsec_s timeMinSec_reg;
   logic [15:0] timeMthDay_reg;
   logic [15:0] timeYear_reg;
   logic [15:0] alarmMthDay_reg;
   rtv_wdhr_s   alarmWdHr_reg;
   rtv_minsec_s alarmMinSec_reg;

   logic        wrEn;
   logic [1:0]  timePtr;
   logic [1:0]  alarmPtr;
   logic        runOn;
   logic        tick;
   logic        wrTime;
   logic        wrAlarm;
   logic        wrCtrl;
   logic        wrDiv;
   logic [15:0] wd;
   logic [31:0] rdData_next;

   assign wrEn     = ctrl_reg[RTV_CTRL_WREN_BIT];
   assign timePtr  = ctrl_reg[RTV_CTRL_TPTR_LSB +: 2];
   assign alarmPtr = ctrl_reg[RTV_CTRL_APTR_LSB +: 2];
   assign runOn    = ctrl_reg[RTV_CTRL_RUN_BIT];
   assign wd       = busReq.wdata[15:0];
   assign wrTime   = busReq.wr && busReq.addr == RTV_TIME_WIN_OFS;
   assign wrAlarm  = busReq.wr && busReq.addr == RTV_ALARM_WIN_OFS;
   assign wrCtrl   = busReq.wr && busReq.addr == RTV_CTRL_OFS;
   assign wrDiv    = busReq.wr && busReq.addr == RTV_TICK_DIV_OFS;
   assign tick     = runOn && tickCnt_reg == 32'h0000_0000;

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         ctrl_reg    <= RTV_CTRL_RST;
         tickDiv_reg <= TICK_DIV;
      end
      else
      begin
         if (wrCtrl)
            ctrl_reg <= busReq.wdata[15:0] & 16'h1331;
         if (wrDiv)
            tickDiv_reg <= busReq.wdata;
      end
   end

   // Seconds prescaler; divider 0 means a tick every cycle
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         tickCnt_reg <= 32'h0000_0000;
      else if (!runOn || tickCnt_reg == 32'h0000_0000)
         tickCnt_reg <= tickDiv_reg - 32'h0000_0001 == 32'hFFFF_FFFF
                        ? 32'h0000_0000 : tickDiv_reg - 32'h0000_0001;
      else
         tickCnt_reg <= tickCnt_reg - 32'h0000_0001;
   end

   // ----------------------------------------------------------------
   // Current time cascade
   // ----------------------------------------------------------------
   logic cSec;
   logic cMin;
   logic cHour;
   logic hrTop;
   assign cSec  = timeMinSec_reg.second_ones_digit == RTV_MAX_ONES &&
                  timeMinSec_reg.second_tens_digit == RTV_MAX_TEN6;
   assign cMin  = cSec && timeMinSec_reg.minute_ones_digit == RTV_MAX_ONES &&
                  timeMinSec_reg.minute_tens_digit == RTV_MAX_TEN6;
   assign hrTop = timeWdHr_reg.hour_tens_digit == RTV_MAX_HOUR_TENS_DIGIT &&
                  timeWdHr_reg.hour_ones_digit == RTV_MAX_HR_ONE2X;
   assign cHour = cMin && hrTop;

   // Value contents are not reset: software must load them
   always_ff @(posedge clk)
   begin
      if (wrTime && timePtr == RTV_PTR_MIN_SEC)
         timeMinSec_reg <= rtv_minsec_s'({wd[14:8], wd[6:0]});
      else if (tick)
      begin
         if (timeMinSec_reg.second_ones_digit == RTV_MAX_ONES)
         begin
            timeMinSec_reg.second_ones_digit <= 4'h0;
            if (timeMinSec_reg.second_tens_digit == RTV_MAX_TEN6)
               timeMinSec_reg.second_tens_digit <= 3'h0;
            else
               timeMinSec_reg.second_tens_digit <= timeMinSec_reg.second_tens_digit + 3'h1;
         end
         else
            timeMinSec_reg.second_ones_digit <= timeMinSec_reg.second_ones_digit + 4'h1;
         if (cSec)
         begin
            if (timeMinSec_reg.minute_ones_digit == RTV_MAX_ONES)
            begin
               timeMinSec_reg.minute_ones_digit <= 4'h0;
               if (timeMinSec_reg.minute_tens_digit == RTV_MAX_TEN6)
                  timeMinSec_reg.minute_tens_digit <= 3'h0;
               else
                  timeMinSec_reg.minute_tens_digit <= timeMinSec_reg.minute_tens_digit + 3'h1;
            end
            else
               timeMinSec_reg.minute_ones_digit <= timeMinSec_reg.minute_ones_digit + 4'h1;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (wrTime && wrEn && timePtr == RTV_PTR_WEEKDAY_DIGIT_HOUR)
         timeWdHr_reg <= rtv_wdhr_s'({wd[10:8], wd[5:0]});
      else if (tick && cMin)
      begin
         if (hrTop)
            timeWdHr_reg.hour_tens_digit <= 2'h0;
         else if (timeWdHr_reg.hour_ones_digit == RTV_MAX_ONES)
            timeWdHr_reg.hour_tens_digit <= timeWdHr_reg.hour_tens_digit + 2'h1;
         if (hrTop || timeWdHr_reg.hour_ones_digit == RTV_MAX_ONES)
            timeWdHr_reg.hour_ones_digit <= 4'h0;
         else
            timeWdHr_reg.hour_ones_digit <= timeWdHr_reg.hour_ones_digit + 4'h1;
         if (cHour)
            timeWdHr_reg.weekday_digit <= timeWdHr_reg.weekday_digit == RTV_MAX_WEEKDAY_DIGIT
                                 ? 3'h0 : timeWdHr_reg.weekday_digit + 3'h1;
      end
   end

   // Date and year words are held for the window; nothing in this
   // project counts them, they change only on software writes
   always_ff @(posedge clk)
   begin
      if (wrTime && wrEn && timePtr == RTV_PTR_MONTH_DAY)
         timeMthDay_reg <= wd & RTV_MASK_MONTH_DAY;
      if (wrTime && wrEn && timePtr == RTV_PTR_YEAR)
         timeYear_reg <= wd & RTV_MASK_YEAR;
   end

   // ----------------------------------------------------------------
   // Alarm values
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (wrAlarm && wrEn && alarmPtr == RTV_PTR_MONTH_DAY)
         alarmMthDay_reg <= wd & RTV_MASK_MONTH_DAY;
      if (wrAlarm && wrEn && alarmPtr == RTV_PTR_WEEKDAY_DIGIT_HOUR)
         alarmWdHr_reg <= rtv_wdhr_s'({wd[10:8], wd[5:0]});
      if (wrAlarm && alarmPtr == RTV_PTR_MIN_SEC)
         alarmMinSec_reg <= rtv_minsec_s'({wd[14:8], wd[6:0]});
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   function automatic logic [15:0] packWdHr(rtv_wdhr_s v);
      packWdHr = {5'h00, v.weekday_digit, 2'h0, v.hour_tens_digit, v.hour_ones_digit};
   endfunction : packWdHr

   function automatic logic [15:0] packMinSec(rtv_minsec_s v);
      packMinSec = {1'b0, v.minute_tens_digit, v.minute_ones_digit, 1'b0, v.second_tens_digit, v.second_ones_digit};
   endfunction : packMinSec

   always_comb
   begin
      rdData_next = 32'h0000_0000;
      if (busReq.addr == RTV_CTRL_OFS)
         rdData_next = {16'h0000, ctrl_reg};
      else if (busReq.addr == RTV_TICK_DIV_OFS)
         rdData_next = tickDiv_reg;
      else if (busReq.addr == RTV_TIME_WIN_OFS)
      begin
         case (timePtr)
            RTV_PTR_MIN_SEC:   rdData_next[15:0] = packMinSec(timeMinSec_reg);
            RTV_PTR_WEEKDAY_DIGIT_HOUR: rdData_next[15:0] = packWdHr(timeWdHr_reg);
            RTV_PTR_MONTH_DAY: rdData_next[15:0] = timeMthDay_reg;
            default:           rdData_next[15:0] = timeYear_reg;
         endcase
      end
      else if (busReq.addr == RTV_ALARM_WIN_OFS)
      begin
         case (alarmPtr)
            RTV_PTR_MIN_SEC:   rdData_next[15:0] = packMinSec(alarmMinSec_reg);
            RTV_PTR_WEEKDAY_DIGIT_HOUR: rdData_next[15:0] = packWdHr(alarmWdHr_reg);
            RTV_PTR_MONTH_DAY: rdData_next[15:0] = alarmMthDay_reg;
            default:           rdData_next[15:0] = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
         rdData <= 32'h0000_0000;
      else if (busReq.rd)
         rdData <= rdData_next;
      else
         rdData <= 32'h0000_0000;
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   chk_wdhr_gate: assert property (@(posedge clk) disable iff (!rst_b)
      wrTime && !wrEn && timePtr == RTV_PTR_WEEKDAY_DIGIT_HOUR && !(tick && cMin)
      |=> $stable(timeWdHr_reg))
      else $error("Weekday/hours changed without write enable");

   chk_alarm_gate: assert property (@(posedge clk) disable iff (!rst_b)
      wrAlarm && !wrEn |=> $stable(alarmMthDay_reg) && $stable(alarmWdHr_reg))
      else $error("Alarm word changed without write enable");

   chk_weekday_digit_range: assert property (@(posedge clk) disable iff (!rst_b)
      tick && cHour && timeWdHr_reg.weekday_digit == RTV_MAX_WEEKDAY_DIGIT
      && !(wrTime && timePtr == RTV_PTR_WEEKDAY_DIGIT_HOUR)
      |=> timeWdHr_reg.weekday_digit == 3'h0)
      else $error("Weekday did not wrap after six");

   chk_hour_wrap: assert property (@(posedge clk) disable iff (!rst_b)
      tick && cHour && !(wrTime && timePtr == RTV_PTR_WEEKDAY_DIGIT_HOUR)
      |=> timeWdHr_reg.hour_tens_digit == 2'h0 && timeWdHr_reg.hour_ones_digit == 4'h0)
      else $error("Hours did not wrap after 23");

   chk_min_pos: assert property (@(posedge clk) disable iff (!rst_b)
      busReq.rd && busReq.addr == RTV_TIME_WIN_OFS && timePtr == RTV_PTR_MIN_SEC
      |=> rdData[14:8] == $past({timeMinSec_reg.minute_tens_digit, timeMinSec_reg.minute_ones_digit}))
      else $error("Minute digits misplaced on read");

   chk_sec_carry: assert property (@(posedge clk) disable iff (!rst_b)
      tick && cSec && !wrTime |=> timeMinSec_reg.second_tens_digit == 3'h0
      && timeMinSec_reg.second_ones_digit == 4'h0)
      else $error("Seconds did not wrap after 59");

   chk_zero_bits: assert property (@(posedge clk) disable iff (!rst_b)
      busReq.rd && busReq.addr == RTV_TIME_WIN_OFS && timePtr == RTV_PTR_WEEKDAY_DIGIT_HOUR
      |=> (rdData & ~{16'h0000, RTV_MASK_WEEKDAY_DIGIT_HOUR}) == 32'h0000_0000)
      else $error("Unimplemented bits read nonzero");

   chk_month_pos: assert property (@(posedge clk) disable iff (!rst_b)
      wrAlarm && wrEn && alarmPtr == RTV_PTR_MONTH_DAY
      ##1 busReq.rd && busReq.addr == RTV_ALARM_WIN_OFS && alarmPtr == RTV_PTR_MONTH_DAY
      |=> rdData[15:0] == ($past(wd, 2) & 16'h1F3F) )
      else $error("Alarm month/day readback wrong");

   cov_sec_tick: cover property (@(posedge clk) disable iff (!rst_b) tick && cSec);
   cov_hour_wrap: cover property (@(posedge clk) disable iff (!rst_b) tick && cHour);
   cov_gated_wr: cover property (@(posedge clk) disable iff (!rst_b) wrAlarm && !wrEn);
   cov_ms_write: cover property (@(posedge clk) disable iff (!rst_b) wrTime && tick);
   cov_alarm_rd: cover property (@(posedge clk) disable iff (!rst_b)
      busReq.rd && busReq.addr == RTV_ALARM_WIN_OFS);

   // ----------------------------------------------------------------
   // Read path, write landing and counting checks
   // ----------------------------------------------------------------
   // Idle cycles must read zero so a bus OR of many slaves stays clean
   chk_rd_idle: assert property (@(posedge clk)
      disable iff (!rst_b) !busReq.rd |=> rdData == 32'h0000_0000)
      else $error("Read data not zero while idle");

   chk_year_pos: assert property (@(posedge clk)
      disable iff (!rst_b) busReq.rd && busReq.addr == RTV_TIME_WIN_OFS
      && timePtr == RTV_PTR_YEAR |=> rdData == {16'h0000, $past(timeYear_reg)})
      else $error("Year word misread");

   chk_year_gate: assert property (@(posedge clk)
      disable iff (!rst_b) wrTime && !wrEn && timePtr == RTV_PTR_YEAR
      |=> $stable(timeYear_reg))
      else $error("Year word changed without write enable");

   chk_alarm_ms_wr: assert property (@(posedge clk)
      disable iff (!rst_b) wrAlarm && alarmPtr == RTV_PTR_MIN_SEC
      |=> alarmMinSec_reg == $past(rtv_minsec_s'({wd[14:8], wd[6:0]})))
      else $error("Alarm minutes/seconds write lost");

   // Software write must win over a count landing in the same cycle
   chk_time_ms_wr: assert property (@(posedge clk)
      disable iff (!rst_b) wrTime && timePtr == RTV_PTR_MIN_SEC
      |=> timeMinSec_reg == $past(rtv_minsec_s'({wd[14:8], wd[6:0]})))
      else $error("Time minutes/seconds write lost");

   chk_alarm_wdhr_rd: assert property (@(posedge clk)
      disable iff (!rst_b) busReq.rd && busReq.addr == RTV_ALARM_WIN_OFS
      && alarmPtr == RTV_PTR_WEEKDAY_DIGIT_HOUR |=> rdData[15:0] == {5'h00,
      $past(alarmWdHr_reg.weekday_digit), 2'h0, $past(alarmWdHr_reg.hour_tens_digit),
      $past(alarmWdHr_reg.hour_ones_digit)})
      else $error("Alarm weekday/hours misread");

   chk_alarm_ptr3: assert property (@(posedge clk)
      disable iff (!rst_b) busReq.rd && busReq.addr == RTV_ALARM_WIN_OFS
      && alarmPtr == RTV_PTR_YEAR |=> rdData == 32'h0000_0000)
      else $error("Unused alarm pointer read nonzero");

   chk_ms_zero: assert property (@(posedge clk)
      disable iff (!rst_b) busReq.rd && busReq.addr == RTV_TIME_WIN_OFS
      && timePtr == RTV_PTR_MIN_SEC
      |=> !rdData[15] && !rdData[7] && rdData[31:16] == 16'h0000)
      else $error("Minutes/seconds reserved bits nonzero");

   chk_sec_step: assert property (@(posedge clk)
      disable iff (!rst_b) tick && !wrTime
      && timeMinSec_reg.second_ones_digit != RTV_MAX_ONES
      |=> timeMinSec_reg.second_ones_digit == $past(timeMinSec_reg.second_ones_digit) + 4'h1)
      else $error("Seconds ones did not step");

   chk_weekday_digit_hold: assert property (@(posedge clk)
      disable iff (!rst_b) tick && cMin && !cHour && !wrTime
      |=> $stable(timeWdHr_reg.weekday_digit))
      else $error("Weekday moved without a day carry");

   chk_md_mask: assert property (@(posedge clk)
      disable iff (!rst_b) busReq.rd && busReq.addr == RTV_ALARM_WIN_OFS
      && alarmPtr == RTV_PTR_MONTH_DAY
      |=> (rdData & ~{16'h0000, RTV_MASK_MONTH_DAY}) == 32'h0000_0000)
      else $error("Alarm month/day reserved bits nonzero");

   chk_div_rd: assert property (@(posedge clk)
      disable iff (!rst_b) busReq.rd && busReq.addr == RTV_TICK_DIV_OFS
      |=> rdData == $past(tickDiv_reg))
      else $error("Divider misread");

endmodule : rtv_value_regs

// [rtv_pkg.sv]
// Package for the clock/calendar value registers
package rtv_pkg;

   // ----------------------------------------------------------------
   // Register map (word indices on the plain register port)
   // ----------------------------------------------------------------
   localparam logic [3:0] RTV_CTRL_OFS       = 4'h0;
   localparam logic [3:0] RTV_TIME_WIN_OFS   = 4'h1;
   localparam logic [3:0] RTV_ALARM_WIN_OFS  = 4'h2;
   localparam logic [3:0] RTV_TICK_DIV_OFS   = 4'h3;

   // Control register fields
   localparam int RTV_CTRL_WREN_BIT   = 0;
   localparam int RTV_CTRL_TPTR_LSB   = 4;
   localparam int RTV_CTRL_APTR_LSB   = 8;
   localparam int RTV_CTRL_RUN_BIT    = 12;

   // ----------------------------------------------------------------
   // Window pointer codes
   // ----------------------------------------------------------------
   localparam logic [1:0] RTV_PTR_MIN_SEC    = 2'b00;
   localparam logic [1:0] RTV_PTR_WEEKDAY_DIGIT_HOUR  = 2'b01;
   localparam logic [1:0] RTV_PTR_MONTH_DAY  = 2'b10;
   localparam logic [1:0] RTV_PTR_YEAR       = 2'b11;

   // ----------------------------------------------------------------
   // Field positions inside a 16-bit value word
   // ----------------------------------------------------------------
   localparam int RTV_WEEKDAY_DIGIT_LSB     = 8;
   localparam int RTV_HOUR_TENS_DIGIT_LSB    = 4;
   localparam int RTV_MINUTE_TENS_DIGIT_LSB   = 12;
   localparam int RTV_MINUTE_ONES_DIGIT_LSB   = 8;
   localparam int RTV_SECOND_TENS_DIGIT_LSB   = 4;
   localparam int RTV_MTHTEN_BIT   = 12;
   localparam int RTV_MONTH_ONES_DIGIT_LSB   = 8;
   localparam int RTV_DAY_TENS_DIGIT_LSB   = 4;
   localparam int RTV_YEAR_TENS_DIGIT_LSB    = 4;

   // Masks of implemented bits; other bits read zero
   localparam logic [15:0] RTV_MASK_WEEKDAY_DIGIT_HOUR = 16'h073F;
   localparam logic [15:0] RTV_MASK_MIN_SEC   = 16'h7F7F;
   localparam logic [15:0] RTV_MASK_MONTH_DAY = 16'h1F3F;
   localparam logic [15:0] RTV_MASK_YEAR      = 16'h00FF;

   // Field upper limits; the counting cascade uses all but the day tens limit
   localparam logic [3:0] RTV_MAX_ONES     = 4'h9;
   localparam logic [2:0] RTV_MAX_TEN6     = 3'h5;
   localparam logic [2:0] RTV_MAX_WEEKDAY_DIGIT     = 3'h6;
   localparam logic [1:0] RTV_MAX_HOUR_TENS_DIGIT    = 2'h2;
   localparam logic [3:0] RTV_MAX_HR_ONE2X = 4'h3;
   localparam logic [1:0] RTV_MAX_DAY_TENS_DIGIT   = 2'h3;

   // Reset values of control state
   localparam logic [15:0] RTV_CTRL_RST    = 16'h0000;
   localparam logic [31:0] RTV_TICKDIV_RST = 32'd125_000_000;

   // ----------------------------------------------------------------
   // Carrier types
   // ----------------------------------------------------------------
   typedef struct packed
   {
      logic [3:0] addr;
      logic [31:0] wdata;
      logic       wr;
      logic       rd;
   } rtv_req_s;

   typedef struct packed
   {
      logic [2:0] weekday_digit;
      logic [1:0] hour_tens_digit;
      logic [3:0] hour_ones_digit;
   } rtv_wdhr_s;

   typedef struct packed
   {
      logic [2:0] minute_tens_digit;
      logic [3:0] minute_ones_digit;
      logic [2:0] second_tens_digit;
      logic [3:0] second_ones_digit;
   } rtv_minsec_s;

endpackage : rtv_pkg

// [rtv_value_regs_tb.sv]
// Self-checking bench for the clock/calendar value registers
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end

module rtv_value_regs_tb;
   import rtv_pkg::*;

   // ------------------------------------------------------------
   // Signals and bookkeeping
   // ------------------------------------------------------------
   typedef struct { logic chk; logic [31:0] val; } rtv_note_s;
   logic              clk = 1'b0;
   logic              rst_b = 1'b0;
   rtv_req_s          busReq = '0;
   logic [31:0]       rdData;
   logic              dv = 1'b0;
   logic [31:0]       lastRd = 32'h0000_0000;
   logic [7:0]        lfsr = 8'h52;
   logic [15:0]       tv [4];
   logic [15:0]       av [4];
   rtv_note_s         q[$];
   rtv_note_s         nt;
   int                n_errors = 0;
   int                compares = 0;

   always #4 clk = ~clk;

   rtv_value_regs #(.TICK_DIV(32'h0000_0004)) dut
   (
      .clk    (clk),
      .rst_b  (rst_b),
      .busReq (busReq),
      .rdData (rdData)
   );

   // ------------------------------------------------------------
   // Stimulus helpers
   // ------------------------------------------------------------
   function automatic logic [3:0] dg(input int m);
      lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      return 4'(lfsr % (m + 1));
   endfunction : dg

   function automatic logic [15:0] msk(input logic [1:0] p);
      case (p)
         2'h0:    return RTV_MASK_MIN_SEC;
         2'h1:    return RTV_MASK_WEEKDAY_DIGIT_HOUR;
         2'h2:    return RTV_MASK_MONTH_DAY;
         default: return RTV_MASK_YEAR;
      endcase
   endfunction : msk

   // In-range digits; reserved bits get junk that must read back zero
   function automatic logic [15:0] gen(input logic [1:0] p);
      logic [15:0] v;
      logic [15:0] j;
      j = {dg(15), dg(15), dg(15), dg(15)};
      case (p)
         2'h0:    v = {1'h0, 3'(dg(5)), dg(9), 1'h0, 3'(dg(5)), dg(9)};
         2'h1:    v = {5'h00, 3'(dg(6)), 2'h0, 2'(dg(2)), dg(9)};
         2'h2:    v = {3'h0, 1'(dg(1)), dg(9), 2'h0, 2'(dg(3)), dg(9)};
         default: v = {8'h00, dg(9), dg(9)};
      endcase
      return v | (j & ~msk(p));
   endfunction : gen

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
   endtask : wr

   task automatic rd(input logic [3:0] a, input logic [31:0] e,
                     input logic c);
      @(posedge clk);
      busReq <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
      q.push_back('{chk: c, val: e});
   endtask : rd

   task automatic setc(input logic w, input logic [1:0] tp,
                       input logic [1:0] ap, input logic run);
      wr(RTV_CTRL_OFS, (32'(w) << RTV_CTRL_WREN_BIT)
         | (32'(tp) << RTV_CTRL_TPTR_LSB) | (32'(ap) << RTV_CTRL_APTR_LSB)
         | (32'(run) << RTV_CTRL_RUN_BIT));
   endtask : setc

   // Bounded wait until every pending read has been judged
   task automatic drain;
      int k;
      @(posedge clk);
      busReq <= '0;
      k = 0;
      while (q.size() != 0 && k < 10)
      begin
         @(posedge clk);
         k++;
      end
      if (q.size() != 0)
      begin
         n_errors++;
         wrap_up();
      end
   endtask : drain

   task automatic wrap_up;
      $display("compares=%0d n_errors=%0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : wrap_up

   // ------------------------------------------------------------
   // Output watcher: read data only in the cycle after the strobe
   // ------------------------------------------------------------
   always @(posedge clk)
   begin
      dv <= busReq.rd & rst_b;
   end

   always @(negedge clk)
   begin
      if (rst_b === 1'b1)
      begin
         if (dv === 1'b1 && q.size() != 0)
         begin
            nt = q.pop_front();
            lastRd = rdData;
            if (nt.chk === 1'b1)
               `CHK(rdData, nt.val)
         end
         else
            `CHK(rdData, 32'h0000_0000)
      end
   end

   initial
   begin
      repeat (50000) @(posedge clk);
      n_errors++;
      wrap_up();
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   task automatic chk_all(input logic w);
      for (int p = 0; p < 4; p++)
      begin
         setc(w, 2'(p), 2'(p), 1'b0);
         rd(RTV_TIME_WIN_OFS, {16'h0000, tv[p] & msk(2'(p))}, 1'b1);
         rd(RTV_ALARM_WIN_OFS, (p == 3) ? 32'h0000_0000
            : {16'h0000, av[p] & msk(2'(p))}, 1'b1);
      end
      drain();
   endtask : chk_all

   logic [15:0] tb_h [3] = '{16'h0623, 16'h0209, 16'h0119};
   logic [15:0] tb_m [3] = '{16'h5959, 16'h5959, 16'h0509};
   logic [15:0] ex_h [3] = '{16'h0000, 16'h0210, 16'h0119};
   logic [15:0] ex_m [3] = '{16'h0000, 16'h0000, 16'h0510};

   initial
   begin
      int k;
      logic [15:0] nv;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      // Each pointer code reaches its own word, except alarm code 3 which has none; upper bus bits ignored
      for (int p = 0; p < 4; p++)
      begin
         setc(1'b1, 2'(p), 2'(p), 1'b0);
         tv[p] = gen(2'(p));
         av[p] = gen(2'(p));
         wr(RTV_TIME_WIN_OFS, {dg(15), dg(15), dg(15), dg(15), tv[p]});
         wr(RTV_ALARM_WIN_OFS, {dg(15), dg(15), dg(15), dg(15), av[p]});
      end
      chk_all(1'b1);
      // With the enable clear only minutes/seconds words take writes
      for (int p = 0; p < 4; p++)
      begin
         setc(1'b0, 2'(p), 2'(p), 1'b0);
         nv = gen(2'(p));
         wr(RTV_TIME_WIN_OFS, {16'h0000, nv});
         if (p == 0) tv[0] = nv;
         nv = gen(2'(p));
         wr(RTV_ALARM_WIN_OFS, {16'h0000, nv});
         if (p == 0) av[0] = nv;
      end
      chk_all(1'b0);
      for (int a = 4; a < 16; a++)
         rd(4'(a), 32'h0000_0000, 1'b1);
      rd(RTV_CTRL_OFS, 32'h0000_0330, 1'b1);
      wr(RTV_TICK_DIV_OFS, 32'h0000_00C8);
      rd(RTV_TICK_DIV_OFS, 32'h0000_00C8, 1'b1);
      drain();
      // Cascade: one tick from each start word, then stop and read back
      for (int i = 0; i < 3; i++)
      begin
         setc(1'b1, 2'h1, 2'h0, 1'b0);
         wr(RTV_TIME_WIN_OFS, {16'h0000, tb_h[i]});
         setc(1'b1, 2'h0, 2'h0, 1'b0);
         wr(RTV_TIME_WIN_OFS, {16'h0000, tb_m[i]});
         setc(1'b1, 2'h0, 2'h0, 1'b1);
         k = 0;
         do
         begin
            rd(RTV_TIME_WIN_OFS, 32'h0000_0000, 1'b0);
            drain();
            k++;
         end
         while (lastRd === {16'h0000, tb_m[i]} && k < 150);
         if (k >= 150)
         begin
            n_errors++;
            wrap_up();
         end
         setc(1'b1, 2'h0, 2'h0, 1'b0);
         rd(RTV_TIME_WIN_OFS, {16'h0000, ex_m[i]}, 1'b1);
         setc(1'b1, 2'h1, 2'h0, 1'b0);
         rd(RTV_TIME_WIN_OFS, {16'h0000, ex_h[i]}, 1'b1);
         drain();
      end
      wrap_up();
   end

endmodule : rtv_value_regs_tb
